// ===== hw/flvic_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit register address space on the plain register port
`ifndef FLVIC_REGS_SVH
`define FLVIC_REGS_SVH

`define FLVIC_OFS_IRQ_ENABLE 8'hA8
`define FLVIC_OFS_PRIO_LOW 8'hB8
`define FLVIC_OFS_PRIO_HIGH 8'hB7
`define FLVIC_OFS_TIMER_CTRL 8'h88
`define FLVIC_OFS_UART_CTRL 8'h98
`define FLVIC_OFS_SPI_STAT 8'hE1
`define FLVIC_OFS_PIN_FLAGS 8'hE2
`define FLVIC_OFS_CMP_CTRL 8'hE3
`define FLVIC_OFS_IN_SERVICE 8'hE4

`define FLVIC_RST_IRQ_ENABLE 8'h00
`define FLVIC_RST_PRIO 8'h00

`define FLVIC_BIT_GLOBAL_GATE 7
`define FLVIC_BIT_EXT_A_TYPE 0
`define FLVIC_BIT_EXT_A_FLAG 1
`define FLVIC_BIT_EXT_B_TYPE 2
`define FLVIC_BIT_EXT_B_FLAG 3
`define FLVIC_BIT_TIMER_A_OVF 5
`define FLVIC_BIT_TIMER_B_OVF 7
`define FLVIC_BIT_UART_RX 0
`define FLVIC_BIT_UART_TX 1
`define FLVIC_BIT_SPI_DONE 7
`define FLVIC_BIT_CMP_FLAG 4

`define FLVIC_VEC_RESET 16'h0000
`define FLVIC_VEC_BASE 16'h0003
`define FLVIC_VEC_STEP 16'h0008
`define FLVIC_CALL_CYCLES 4

`endif

// ===== hw/flvic_pkg.sv
// types shared by the interrupt controller and its surroundings
// assumes flvic_regs.svh for all numeric constants
package flvic_pkg;

    // hardware call request handed to the instruction sequencer
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [15:0] vector;
    } flvic_call_type;

    typedef enum logic [1:0] {
        ST_POLL = 2'b01,
        ST_CALL = 2'b10
    } flvic_state_type;

endpackage

// ===== hw/flvic_ctrl.sv
// four-level vectored interrupt controller with its request flags
// assumes a cpu sequencer giving last-cycle and return-from-irq marks
//
// Notes on behaviour
// R1 - reset at 0000H, sources from 0003H spaced eight bytes to 0033H
// R2 - each source has its own enable bit in irq_enable
// R3 - global gate bit 7 clear blocks all; set defers to source enables
// R4 - six sources pick one of four levels from low and high bits
// R5 - comparator always sits at the lowest level
// R6 - only a strictly higher level preempts; top level never preempted
// R7 - highest pending level wins; ties go to lower vector address
// R8 - each external input selects level or edge and sets its flag
// R9 - external flag cleared on vectoring only in edge mode
// R10 - timer overflow flags set on rollover, cleared on vectoring
// R11 - serial request ORs uart rx, uart tx and spi done; none cleared
// R12 - pin group request ORs eight pin flags; vectoring leaves them
// R13 - level pin sources must release before software clears the flag
// R14 - comparator request from its flag, never cleared on vectoring
// R15 - software writes to flags act like hardware set or clear
// R16 - spi done and pin flags: hardware sets, software only clears
// R17 - poll in last instruction cycle using previous cycle values
// R18 - no call if equal or higher in service, in return, or enable write
// R19 - blocked requests gone at unblock are dropped; every poll is new
// R20 - accepted request issues a four-cycle long call next
// R21 - single-irq latency above five and below thirteen cycles
// R22 - level is {high bit, low bit} at same position, bits 0 to 5
// R23 - in-service record per level, set on vectoring, cleared by return
`include "flvic_regs.svh"

module flvic_ctrl #(
    parameter int NUM_PIN_IRQ = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // external interrupt pins, active low, asynchronous
    input wire logic ext_a_pin_n,
    input wire logic ext_b_pin_n,
    // peripheral set pulses, same clock
    input wire logic timer_a_overflow_set,
    input wire logic timer_b_overflow_set,
    input wire logic uart_rx_done_set,
    input wire logic uart_tx_done_set,
    input wire logic spi_done_set,
    input wire logic [NUM_PIN_IRQ-1:0] pin_irq_set,
    input wire logic comparator_set,
    // cpu sequencer
    input wire logic instr_last,
    input wire logic return_from_irq,
    output flvic_pkg::flvic_call_type long_call,
    output logic call_busy,
    output logic [3:0] in_service
);

    localparam int NSRC = 7;
    localparam int CMP_IDX = 6;

    // level of a source from its pair of priority bits
    function automatic logic [1:0] src_level(
        input logic [7:0] lo,
        input logic [7:0] hi,
        input int idx
    );
        logic [1:0] lvl;
        lvl = 2'b00;
        if (idx != CMP_IDX)
        begin
            lvl = {hi[idx], lo[idx]}; // [R4] [R22]
        end
        return lvl; // [R5]
    endfunction

    // highest set level of a four-bit in-service record
    function automatic logic [1:0] top_level(input logic [3:0] rec);
        logic [1:0] lvl;
        lvl = 2'b00;
        for (int i = 0; i < 4; i++)
        begin
            if (rec[i])
            begin
                lvl = i[1:0];
            end
        end
        return lvl;
    endfunction

    // registers
    logic [7:0] irq_enable_r;
    logic [7:0] prio_low_r;
    logic [7:0] prio_high_r;
    logic ext_a_type_r;
    logic ext_b_type_r;
    logic ext_a_flag_r;
    logic ext_b_flag_r;
    logic timer_a_ovf_r;
    logic timer_b_ovf_r;
    logic uart_rx_r;
    logic uart_tx_r;
    logic spi_done_r;
    logic [NUM_PIN_IRQ-1:0] pin_flags_r;
    logic cmp_flag_r;
    logic [7:0] rdata_r;

    // pin synchronisers and edge history
    logic [1:0] ext_a_sync_r;
    logic [1:0] ext_b_sync_r;
    logic ext_a_prev_r;
    logic ext_b_prev_r;

    // polling and call sequencing
    logic [NSRC-1:0] req_prev_r;
    logic blk_access_r;
    logic [3:0] isr_r;
    flvic_pkg::flvic_state_type state_r;
    logic [2:0] call_cnt_r;
    flvic_pkg::flvic_call_type call_r;

    // register decode
    wire wr_enable = reg_wr && (reg_addr == `FLVIC_OFS_IRQ_ENABLE);
    wire wr_prio_lo = reg_wr && (reg_addr == `FLVIC_OFS_PRIO_LOW);
    wire wr_prio_hi = reg_wr && (reg_addr == `FLVIC_OFS_PRIO_HIGH);
    wire wr_timer_ctrl = reg_wr && (reg_addr == `FLVIC_OFS_TIMER_CTRL);
    wire wr_uart = reg_wr && (reg_addr == `FLVIC_OFS_UART_CTRL);
    wire wr_spi = reg_wr && (reg_addr == `FLVIC_OFS_SPI_STAT);
    wire wr_pin = reg_wr && (reg_addr == `FLVIC_OFS_PIN_FLAGS);
    wire wr_cmp = reg_wr && (reg_addr == `FLVIC_OFS_CMP_CTRL);
    wire wr_prio_any = wr_enable || wr_prio_lo || wr_prio_hi;

    // external pin levels after synchronising, active high request
    wire ext_a_low = ~ext_a_sync_r[1];
    wire ext_b_low = ~ext_b_sync_r[1];
    wire ext_a_fall = ext_a_prev_r && !ext_a_sync_r[1];
    wire ext_b_fall = ext_b_prev_r && !ext_b_sync_r[1];

    // pending requests gated by enables
    wire serial_req = uart_rx_r || uart_tx_r || spi_done_r; // [R11]
    wire pin_group_req = |pin_flags_r; // [R12]
    wire [NSRC-1:0] raw_req = {cmp_flag_r, pin_group_req, serial_req,
                               timer_b_ovf_r, ext_b_flag_r,
                               timer_a_ovf_r, ext_a_flag_r}; // [R14]
    wire global_gate = irq_enable_r[`FLVIC_BIT_GLOBAL_GATE];
    wire [NSRC-1:0] pend = raw_req & irq_enable_r[NSRC-1:0]
                           & {NSRC{global_gate}}; // [R2] [R3]

    // arbitration over the previous cycle's requests
    logic win_any;
    logic [2:0] win_idx;
    logic [1:0] win_lvl;
    always_comb
    begin
        win_any = 1'b0;
        win_idx = 3'd0;
        win_lvl = 2'b00;
        // ascending index, so a tie keeps the lower vector
        for (int i = 0; i < NSRC; i++)
        begin
            if (req_prev_r[i] && (!win_any ||
                src_level(prio_low_r, prio_high_r, i) > win_lvl)) // [R7]
            begin
                win_any = 1'b1;
                win_idx = i[2:0];
                win_lvl = src_level(prio_low_r, prio_high_r, i);
            end
        end
    end

    wire isr_any = |isr_r;
    wire [1:0] isr_top = top_level(isr_r);
    wire level_ok = !isr_any || (win_lvl > isr_top); // [R6] [R18]
    wire instr_blocks = return_from_irq || blk_access_r
                        || wr_prio_any; // [R18]
    // an unserviced request is not held anywhere, the next poll resamples
    wire accept = (state_r == flvic_pkg::ST_POLL) && instr_last
                  && win_any && level_ok && !instr_blocks; // [R17] [R19]
    wire return_done = return_from_irq && instr_last;

    wire [15:0] win_vector = `FLVIC_VEC_BASE
        + 16'({win_idx, 3'b000}); // [R1]

    // hardware clears on vectoring
    wire clr_ext_a = accept && (win_idx == 3'd0) && ext_a_type_r; // [R9]
    wire clr_timer_a = accept && (win_idx == 3'd1); // [R10]
    wire clr_ext_b = accept && (win_idx == 3'd2) && ext_b_type_r; // [R9]
    wire clr_timer_b = accept && (win_idx == 3'd3); // [R10]

    // flag next values; a hardware set wins over any clear
    wire ext_a_edge_nxt = ext_a_fall ||
        (wr_timer_ctrl ? reg_wdata[`FLVIC_BIT_EXT_A_FLAG]
                       : ext_a_flag_r && !clr_ext_a); // [R8] [R15]
    wire ext_b_edge_nxt = ext_b_fall ||
        (wr_timer_ctrl ? reg_wdata[`FLVIC_BIT_EXT_B_FLAG]
                       : ext_b_flag_r && !clr_ext_b); // [R8] [R15]
    // type bit low selects level: flag tracks the pin
    wire ext_a_flag_nxt = ext_a_type_r ? ext_a_edge_nxt : ext_a_low; // [R9]
    wire ext_b_flag_nxt = ext_b_type_r ? ext_b_edge_nxt : ext_b_low; // [R9]
    wire timer_a_ovf_nxt = timer_a_overflow_set ||
        (wr_timer_ctrl ? reg_wdata[`FLVIC_BIT_TIMER_A_OVF]
                       : timer_a_ovf_r && !clr_timer_a); // [R10] [R15]
    wire timer_b_ovf_nxt = timer_b_overflow_set ||
        (wr_timer_ctrl ? reg_wdata[`FLVIC_BIT_TIMER_B_OVF]
                       : timer_b_ovf_r && !clr_timer_b); // [R10] [R15]
    wire uart_rx_nxt = uart_rx_done_set ||
        (wr_uart ? reg_wdata[`FLVIC_BIT_UART_RX] : uart_rx_r); // [R15]
    wire uart_tx_nxt = uart_tx_done_set ||
        (wr_uart ? reg_wdata[`FLVIC_BIT_UART_TX] : uart_tx_r); // [R15]
    wire spi_done_nxt = spi_done_set || (spi_done_r &&
        !(wr_spi && !reg_wdata[`FLVIC_BIT_SPI_DONE])); // [R16]
    // a level source that keeps setting its flag defeats the clear
    wire [NUM_PIN_IRQ-1:0] pin_flags_nxt = pin_irq_set | (pin_flags_r &
        ~({NUM_PIN_IRQ{wr_pin}} & ~reg_wdata[NUM_PIN_IRQ-1:0])); // [R16] [R13]
    wire cmp_flag_nxt = comparator_set ||
        (wr_cmp ? reg_wdata[`FLVIC_BIT_CMP_FLAG] : cmp_flag_r); // [R15]

    // read mux
    wire [7:0] timer_ctrl_view = {timer_b_ovf_r, 1'b0, timer_a_ovf_r, 1'b0,
                            ext_b_flag_r, ext_b_type_r,
                            ext_a_flag_r, ext_a_type_r};
    logic [7:0] rdata_nxt;
    always_comb
    begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `FLVIC_OFS_IRQ_ENABLE: rdata_nxt = irq_enable_r;
            `FLVIC_OFS_PRIO_LOW: rdata_nxt = {2'b00, prio_low_r[5:0]};
            `FLVIC_OFS_PRIO_HIGH: rdata_nxt = {2'b00, prio_high_r[5:0]};
            `FLVIC_OFS_TIMER_CTRL: rdata_nxt = timer_ctrl_view;
            `FLVIC_OFS_UART_CTRL: rdata_nxt = {6'h00, uart_tx_r, uart_rx_r};
            `FLVIC_OFS_SPI_STAT: rdata_nxt = {spi_done_r, 7'h00};
            `FLVIC_OFS_PIN_FLAGS: rdata_nxt = 8'(pin_flags_r);
            `FLVIC_OFS_CMP_CTRL: rdata_nxt = {3'b000, cmp_flag_r, 4'h0};
            `FLVIC_OFS_IN_SERVICE: rdata_nxt = {4'h0, isr_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // in-service record
    logic [3:0] isr_nxt;
    always_comb
    begin
        isr_nxt = isr_r;
        if (return_done && isr_any)
        begin
            isr_nxt[isr_top] = 1'b0; // [R23]
        end
        if (accept)
        begin
            isr_nxt[win_lvl] = 1'b1; // [R23]
        end
    end

    // call sequencer: four cycles of long call after acceptance
    flvic_pkg::flvic_state_type state_nxt;
    logic [2:0] call_cnt_nxt;
    always_comb
    begin
        state_nxt = state_r;
        call_cnt_nxt = call_cnt_r;
        case (state_r)
            flvic_pkg::ST_POLL:
            begin
                if (accept)
                begin
                    state_nxt = flvic_pkg::ST_CALL;
                    call_cnt_nxt = 3'(`FLVIC_CALL_CYCLES - 1); // [R20]
                end
            end
            flvic_pkg::ST_CALL:
            begin
                if (call_cnt_r == 3'd0)
                begin
                    state_nxt = flvic_pkg::ST_POLL;
                end
                else
                begin
                    call_cnt_nxt = call_cnt_r - 3'd1;
                end
            end
            default:
            begin
                state_nxt = flvic_pkg::ST_POLL;
                call_cnt_nxt = 3'd0;
            end
        endcase
    end

    flvic_pkg::flvic_call_type call_nxt;
    assign call_nxt = '{valid: accept, level: win_lvl,
                        vector: accept ? win_vector : call_r.vector};

    always_ff @(posedge clock)
    begin
        ext_a_sync_r <= {ext_a_sync_r[0], ext_a_pin_n};
        ext_b_sync_r <= {ext_b_sync_r[0], ext_b_pin_n};
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // idle pin level, so no false edge follows reset
            ext_a_prev_r <= 1'b1;
            ext_b_prev_r <= 1'b1;
        end
        else
        begin
            // prev high and now low marks a falling pin
            ext_a_prev_r <= ext_a_sync_r[1];
            ext_b_prev_r <= ext_b_sync_r[1];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irq_enable_r <= `FLVIC_RST_IRQ_ENABLE;
            prio_low_r <= `FLVIC_RST_PRIO;
            prio_high_r <= `FLVIC_RST_PRIO;
            ext_a_type_r <= 1'b0;
            ext_b_type_r <= 1'b0;
        end
        else
        begin
            if (wr_enable)
                irq_enable_r <= reg_wdata;
            if (wr_prio_lo)
                prio_low_r <= reg_wdata;
            if (wr_prio_hi)
                prio_high_r <= reg_wdata;
            if (wr_timer_ctrl)
            begin
                ext_a_type_r <= reg_wdata[`FLVIC_BIT_EXT_A_TYPE]; // [R8]
                ext_b_type_r <= reg_wdata[`FLVIC_BIT_EXT_B_TYPE]; // [R8]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ext_a_flag_r <= 1'b0;
            ext_b_flag_r <= 1'b0;
            timer_a_ovf_r <= 1'b0;
            timer_b_ovf_r <= 1'b0;
            uart_rx_r <= 1'b0;
            uart_tx_r <= 1'b0;
            spi_done_r <= 1'b0;
            pin_flags_r <= '0;
            cmp_flag_r <= 1'b0;
        end
        else
        begin
            ext_a_flag_r <= ext_a_flag_nxt;
            ext_b_flag_r <= ext_b_flag_nxt;
            timer_a_ovf_r <= timer_a_ovf_nxt;
            timer_b_ovf_r <= timer_b_ovf_nxt;
            uart_rx_r <= uart_rx_nxt;
            uart_tx_r <= uart_tx_nxt;
            spi_done_r <= spi_done_nxt;
            pin_flags_r <= pin_flags_nxt;
            cmp_flag_r <= cmp_flag_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            req_prev_r <= '0;
            blk_access_r <= 1'b0;
            isr_r <= 4'h0;
            state_r <= flvic_pkg::ST_POLL;
            call_cnt_r <= 3'd0;
            call_r <= '{valid: 1'b0, level: 2'b00,
                        vector: `FLVIC_VEC_RESET};
            rdata_r <= 8'h00;
        end
        else
        begin
            req_prev_r <= pend; // [R17]
            // an enable or priority write blocks until its instruction ends
            blk_access_r <= !instr_last && (blk_access_r || wr_prio_any);
            isr_r <= isr_nxt;
            state_r <= state_nxt;
            call_cnt_r <= call_cnt_nxt;
            call_r <= call_nxt;
            if (reg_rd)
                rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign long_call = call_r;
    assign call_busy = (state_r == flvic_pkg::ST_CALL); // [R20] [R21]
    assign in_service = isr_r;

endmodule

// ===== testbench/flvic_ctrl_properties.sv
// checker on the call, busy and in-service outputs
// assumes the bind below reaches every flvic_ctrl instance
`include "flvic_regs.svh"

module flvic_ctrl_properties #(
    parameter int NUM_PIN_IRQ = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // cpu sequencer
    input wire logic instr_last,
    input wire logic return_from_irq,
    input wire flvic_pkg::flvic_call_type long_call,
    input wire logic call_busy,
    input wire logic [3:0] in_service
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // shadow of the global gate, seen only through register writes
    logic gate_r;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            gate_r <= 1'h0;
        else if (reg_wr && reg_addr == `FLVIC_OFS_IRQ_ENABLE)
            gate_r <= reg_wdata[`FLVIC_BIT_GLOBAL_GATE];
    end

    call_pulse_a:
        assert property (long_call.valid |=> !long_call.valid)
        else $error("call valid longer than one cycle");
    call_span_a:
        assert property (long_call.valid |-> call_busy[*4] ##1 !call_busy)
        else $error("call busy not four cycles");
    poll_edge_a:
        assert property (long_call.valid |->
            $past(instr_last) && !$past(call_busy))
        else $error("call not after a last instruction cycle");
    return_block_a:
        assert property (long_call.valid |-> !$past(return_from_irq))
        else $error("call right after return");
    vector_map_a:
        assert property (long_call.valid |->
            long_call.vector[2:0] == 3'h3 && long_call.vector <= 16'h0033)
        else $error("vector outside the table");
    cmp_lowest_a:
        assert property (long_call.valid && long_call.vector == 16'h0033
            |-> long_call.level == 2'h0)
        else $error("comparator not at lowest level");
    isr_mark_a:
        assert property (long_call.valid |-> in_service[long_call.level])
        else $error("in-service bit not set on call");
    preempt_a:
        assert property (long_call.valid |->
            ($past(in_service) >> long_call.level) == 4'h0)
        else $error("call without strictly higher level");
    gate_a:
        assert property (long_call.valid |-> $past(gate_r))
        else $error("call with global gate closed");
endmodule

bind flvic_ctrl flvic_ctrl_properties #(.NUM_PIN_IRQ(NUM_PIN_IRQ))
    flvic_ctrl_properties_inst (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .instr_last(instr_last), .return_from_irq(return_from_irq),
    .long_call(long_call), .call_busy(call_busy),
    .in_service(in_service));

// ===== testbench/flvic_cpu_model.sv
// cpu sequencer model: instruction ends and return-from-irq marks
// assumes the controller runs its own call while call_busy is high
module flvic_cpu_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bench controls, length is cycles minus one
    input wire logic [1:0] instr_len,
    input wire logic return_req,
    // controller side
    input wire logic call_busy,
    output logic instr_last,
    output logic return_from_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    logic pend_r;
    logic in_return_r;
    wire at_start = cnt_r == 2'h0 && !call_busy;
    assign instr_last = cnt_r == instr_len && !call_busy;
    // return mark spans the whole instruction, as the core would show it
    assign return_from_irq = at_start ? pend_r : in_return_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cnt_r <= 2'h0;
            pend_r <= 1'h0;
            in_return_r <= 1'h0;
        end
        else
        begin
            cnt_r <= (call_busy || instr_last) ? 2'h0 : cnt_r + 2'h1;
            in_return_r <= return_from_irq && !instr_last;
            pend_r <= return_req || (pend_r && !at_start);
        end
    end
endmodule

// ===== testbench/flvic_ctrl_test.sv
// self-checking bench for the interrupt controller
// assumes the cpu model and checker are compiled before it
module flvic_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pin_set = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_wr = 1'h0, reg_rd = 1'h0, return_req = 1'h0;
    logic ext_a_n = 1'h1, ext_b_n = 1'h1;
    logic [5:0] set_v = 6'h00;
    logic instr_last, return_from_irq, call_busy;
    logic [3:0] in_service;
    flvic_pkg::flvic_call_type long_call;
    int mismatches = 0, compares = 0;
    time t0, t_call;
    always #25 clock = ~clock;

    flvic_ctrl flvic_ctrl_inst (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_a_pin_n(ext_a_n),
        .ext_b_pin_n(ext_b_n), .timer_a_overflow_set(set_v[0]),
        .timer_b_overflow_set(set_v[1]), .uart_rx_done_set(set_v[2]),
        .uart_tx_done_set(set_v[3]), .spi_done_set(set_v[4]),
        .pin_irq_set(pin_set), .comparator_set(set_v[5]),
        .instr_last(instr_last), .return_from_irq(return_from_irq),
        .long_call(long_call), .call_busy(call_busy),
        .in_service(in_service));
    // four-cycle instructions give the longest poll spacing
    flvic_cpu_model flvic_cpu_model_inst (.clock(clock), .rst_n(rst_n),
        .instr_len(2'h3), .return_req(return_req), .call_busy(call_busy),
        .instr_last(instr_last), .return_from_irq(return_from_irq));

    task automatic chk(input string what, input logic [23:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 chk("reg", exp, reg_rdata);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clock);
        t0 = $time;
        set_v <= m;
        @(posedge clock);
        set_v <= 6'h00;
    endtask
    task automatic call(input logic [15:0] vec, input logic [1:0] lvl);
        int n = 0;
        // look only once the launching edge has settled
        #1;
        while (long_call.valid !== 1'h1 && n < 60)
        begin
            @(posedge clock);
            #1 n++;
        end
        t_call = $time;
        chk("call", {1'h1, lvl, vec}, long_call);
        @(posedge clock);
    endtask
    task automatic none(input int n);
        logic seen = 1'h0;
        repeat (n)
        begin
            @(posedge clock);
            #1 seen |= long_call.valid;
        end
        chk("no call", 8'h00, seen);
    endtask
    task automatic ret_irq(input logic [3:0] left);
        int n = 0;
        @(posedge clock);
        return_req <= 1'h1;
        @(posedge clock);
        return_req <= 1'h0;
        #1;
        // a pending request may be taken soon after, so look right away
        while (!(return_from_irq && instr_last) && n < 20)
        begin
            @(posedge clock);
            #1 n++;
        end
        @(posedge clock);
        #1 chk("in service", left, in_service);
    endtask
    task automatic stop_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        rd(8'hA8, 8'h00);
        rd(8'hB8, 8'h00);
        rd(8'hB7, 8'h00);
        rd(8'h5A, 8'h00);
        wr(8'hA8, 8'h02);
        pulse(6'h01);
        none(20);
        wr(8'hA8, 8'h80);
        none(20);
        wr(8'hA8, 8'h82);
        call(16'h000B, 2'h0);
        rd(8'h88, 8'h00);
        ret_irq(4'h0);
        pulse(6'h01);
        call(16'h000B, 2'h0);
        // flag rises one edge after t0; handler starts four after valid
        chk("latency ok", 8'h01,
            (t_call - t0) / 50 + 3 inside {[6:12]});
        ret_irq(4'h0);
        // both timers at level 0: lower vector first, no nesting
        wr(8'hA8, 8'h8A);
        pulse(6'h03);
        call(16'h000B, 2'h0);
        none(20);
        ret_irq(4'h0);
        call(16'h001B, 2'h0);
        ret_irq(4'h0);
        wr(8'hB8, 8'h08);
        wr(8'hB7, 8'h02);
        pulse(6'h03);
        call(16'h000B, 2'h2);
        none(20);
        ret_irq(4'h0);
        call(16'h001B, 2'h1);
        ret_irq(4'h0);
        wr(8'hB7, 8'h00);
        pulse(6'h01);
        call(16'h000B, 2'h0);
        pulse(6'h02);
        call(16'h001B, 2'h1);
        #1 chk("in service", 8'h03, in_service);
        ret_irq(4'h1);
        ret_irq(4'h0);
        wr(8'hB8, 8'h0A);
        wr(8'hB7, 8'h0A);
        pulse(6'h01);
        call(16'h000B, 2'h3);
        pulse(6'h02);
        none(20);
        wr(8'h88, 8'h00);
        ret_irq(4'h0);
        none(20);
        wr(8'h88, 8'h80);
        call(16'h001B, 2'h3);
        ret_irq(4'h0);
        wr(8'hB8, 8'h3F);
        wr(8'hB7, 8'h3F);
        wr(8'hA8, 8'hC0);
        pulse(6'h20);
        call(16'h0033, 2'h0);
        rd(8'hE3, 8'h10);
        wr(8'hA8, 8'h90);
        wr(8'hE3, 8'h00);
        ret_irq(4'h0);
        pulse(6'h10);
        call(16'h0023, 2'h3);
        rd(8'hE1, 8'h80);
        wr(8'hE1, 8'hFF);
        rd(8'hE1, 8'h80);
        wr(8'hE1, 8'h00);
        rd(8'hE1, 8'h00);
        ret_irq(4'h0);
        pulse(6'h04);
        call(16'h0023, 2'h3);
        rd(8'h98, 8'h01);
        wr(8'h98, 8'h00);
        ret_irq(4'h0);
        wr(8'hA8, 8'hA0);
        pin_set <= 8'h20;
        call(16'h002B, 2'h3);
        rd(8'hE2, 8'h20);
        wr(8'hE2, 8'h00);
        rd(8'hE2, 8'h20);
        pin_set <= 8'h00;
        wr(8'hE2, 8'h00);
        rd(8'hE2, 8'h00);
        ret_irq(4'h0);
        wr(8'h88, 8'h01);
        wr(8'hA8, 8'h81);
        ext_a_n <= 1'h0;
        call(16'h0003, 2'h3);
        rd(8'h88, 8'h01);
        ext_a_n <= 1'h1;
        ret_irq(4'h0);
        wr(8'h88, 8'h00);
        wr(8'hA8, 8'h84);
        ext_b_n <= 1'h0;
        call(16'h0013, 2'h3);
        rd(8'h88, 8'h08);
        ext_b_n <= 1'h1;
        repeat (5) @(posedge clock);
        rd(8'h88, 8'h00);
        ret_irq(4'h0);
        stop_test();
    end
endmodule
